/* uart_pair_irq.sv */
// Interrupt status, mask, counter/timer and pin-change detectors for one serial pair
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module uart_pair_irq #(
  parameter int STROBE_CYCLES = uart_pair_irq_pkg::STROBE_DIV
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // AXI4-Lite write channels
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [6:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [6:0]                  s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // Receiver and transmitter events, index 0 is channel a
  input  uart_pair_irq_pkg::rx_evt_t [1:0] rx_evt,
  input  uart_pair_irq_pkg::tx_evt_t [1:0] tx_evt,
  // Pins: I/O0a, I/O1a, I/O0b, I/O1b levels and transmit 1x clocks
  input  wire logic [3:0]                  pin_level,
  input  wire logic [1:0]                  tx_clk_1x,
  // Pin directions, counter/timer output and interrupt
  output logic [7:0]                       pin_oe,
  output logic                             ct_out,
  output logic                             irq_out_n
);
  import uart_pair_irq_pkg::*;

  logic [7:0]  aux_control_reg;
  logic [7:0]  interrupt_mask_reg;
  logic [7:0]  interrupt_status_reg;
  logic [7:0]  interrupt_status_next;
  logic [3:0]  change_flags_reg;
  logic [7:0]  mode_word_zero_reg [2];
  logic [7:0]  mode_word_one_reg [2];
  logic [15:0] preload_reg;
  logic [15:0] count_reg;
  logic [15:0] pin_config_reg;
  logic [3:0]  threshold_reg;
  logic        aw_held_reg;
  logic [4:0]  aw_idx_reg;
  logic        w_held_reg;
  logic [7:0]  wdata_reg;
  logic        wlane0_reg;
  logic        wr_go;
  logic        ar_fire;
  logic [4:0]  ar_idx;
  logic [31:0] rd_val;
  logic        rd_icf;
  logic        rd_start;
  logic        rd_stop;
  logic [15:0] strobe_cnt_reg;
  logic        strobe_en_reg;
  logic [3:0]  xtal_div_reg;
  logic        xtal16_en_reg;
  logic        primed_reg;
  logic [3:0]  confirmed_reg;
  logic [3:0]  pending_reg;
  logic [3:0]  cos_new;
  logic [1:0]  rx_met;
  logic [1:0]  tx_met;
  logic [1:0]  brk_clr;
  logic        pin1_prev_reg;
  logic [1:0]  txclk_prev_reg;
  logic [3:0]  pin_div_reg;
  logic        pin_edge;
  logic        ct_tick;
  logic        timer_mode;
  logic        ct_run_reg;
  logic        ct_phase_reg;
  logic        ct_ready_set;
  logic [3:0]  bid;

  function automatic logic reg_mapped(input logic [4:0] idx);
    return idx <= IDX_THRESH;
  endfunction

  function automatic logic wr_hit(input logic [4:0] idx);
    return wr_go && (aw_idx_reg == idx) && wlane0_reg;
  endfunction

  // Bus decode strobes
  assign wr_go    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_fire  = s_axi_arvalid && s_axi_arready;
  assign ar_idx   = s_axi_araddr[6:2];
  assign rd_icf   = ar_fire && (ar_idx == IDX_ICF);
  assign rd_start = ar_fire && (ar_idx == IDX_START);
  assign rd_stop  = ar_fire && (ar_idx == IDX_STOP);
  assign brk_clr  = {2{wr_hit(IDX_COMMAND)}} & wdata_reg[1:0];

  // Write address channel, held until the write is performed
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_reg   <= 1'b0;
      aw_idx_reg    <= 5'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      aw_idx_reg    <= s_axi_awaddr[6:2];
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_reg;
    end
  end

  // Write data channel, only the low byte lane carries register bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held_reg   <= 1'b0;
      wdata_reg    <= 8'h00;
      wlane0_reg   <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      wdata_reg    <= s_axi_wdata[7:0];
      wlane0_reg   <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_held_reg;
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-written registers; preload bytes are write-only
  always_ff @(posedge mclk) begin
    if (reset) begin
      aux_control_reg    <= AUX_RST;
      interrupt_mask_reg <= IMR_RST;
      preload_reg        <= PRELOAD_RST;
      pin_config_reg     <= PIN_CFG_RST;
      threshold_reg      <= THRESH_RST;
      mode_word_zero_reg <= '{MW_RST, MW_RST};
      mode_word_one_reg  <= '{MW_RST, MW_RST};
    end else begin
      if (wr_hit(IDX_AUX)) aux_control_reg <= wdata_reg;
      if (wr_hit(IDX_IMR)) interrupt_mask_reg <= wdata_reg;
      if (wr_hit(IDX_PRE_HIGH)) preload_reg[15:8] <= wdata_reg;
      if (wr_hit(IDX_PRE_LOW)) preload_reg[7:0] <= wdata_reg;
      if (wr_hit(IDX_PIN_CFG)) pin_config_reg[7:0] <= wdata_reg;
      if (wr_hit(IDX_THRESH)) threshold_reg <= wdata_reg[3:0];
      if (wr_hit(IDX_MW0_A)) mode_word_zero_reg[0] <= wdata_reg;
      if (wr_hit(IDX_MW1_A)) mode_word_one_reg[0] <= wdata_reg;
      if (wr_hit(IDX_MW0_B)) mode_word_zero_reg[1] <= wdata_reg;
      if (wr_hit(IDX_MW1_B)) mode_word_one_reg[1] <= wdata_reg;
    end
  end

  // Read value; status is shown unmasked and pins are read live
  always_comb begin
    rd_val = 32'h0000_0000;
    case (ar_idx)
      IDX_AUX:      rd_val[7:0] = aux_control_reg;
      IDX_ICF:      rd_val[7:0] = {change_flags_reg, pin_level};
      IDX_ISR:      rd_val[7:0] = interrupt_status_reg;
      IDX_IMR:      rd_val[7:0] = interrupt_mask_reg;
      IDX_CNT_HIGH: rd_val[7:0] = count_reg[15:8];
      IDX_CNT_LOW:  rd_val[7:0] = count_reg[7:0];
      IDX_MW0_A:    rd_val[7:0] = mode_word_zero_reg[0];
      IDX_MW1_A:    rd_val[7:0] = mode_word_one_reg[0];
      IDX_MW0_B:    rd_val[7:0] = mode_word_zero_reg[1];
      IDX_MW1_B:    rd_val[7:0] = mode_word_one_reg[1];
      IDX_PIN_CFG:  rd_val[7:0] = pin_config_reg[7:0];
      IDX_THRESH:   rd_val[3:0] = threshold_reg;
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // Read channel; the value is captured at the address handshake
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= reg_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Sampling strobe and crystal divided by 16
  always_ff @(posedge mclk) begin
    if (reset) begin
      strobe_cnt_reg <= 16'h0000;
      strobe_en_reg  <= 1'b0;
      xtal_div_reg   <= 4'h0;
      xtal16_en_reg  <= 1'b0;
    end else begin
      strobe_en_reg  <= (strobe_cnt_reg == 16'(STROBE_CYCLES - 1));
      strobe_cnt_reg <= (strobe_cnt_reg == 16'(STROBE_CYCLES - 1)) ? 16'h0000 : strobe_cnt_reg + 16'h0001;
      xtal16_en_reg  <= (xtal_div_reg == XTAL_DIV_LAST);
      xtal_div_reg   <= xtal_div_reg + 4'h1;
    end
  end

  // First strobe after reset only loads the confirmed levels
  always_ff @(posedge mclk) begin
    if (reset) begin
      primed_reg <= 1'b0;
    end else if (strobe_en_reg) begin
      primed_reg <= 1'b1;
    end
  end

  // Change detectors: two differing strobe samples confirm a change
  generate
    for (genvar k = 0; k < 4; k++) begin : g_detect
      assign cos_new[k] = strobe_en_reg && primed_reg && pending_reg[k]
                          && (pin_level[k] != confirmed_reg[k]);
      always_ff @(posedge mclk) begin
        if (reset) begin
          confirmed_reg[k] <= 1'b0;
          pending_reg[k]   <= 1'b0;
        end else if (strobe_en_reg) begin
          if (!primed_reg || cos_new[k]) begin
            confirmed_reg[k] <= pin_level[k];
            pending_reg[k]   <= 1'b0;
          end else begin
            pending_reg[k]   <= (pin_level[k] != confirmed_reg[k]);
          end
        end
      end
    end
  endgenerate

  // Change flags: a new change wins over a clearing read
  always_ff @(posedge mclk) begin
    if (reset) begin
      change_flags_reg <= 4'h0;
    end else begin
      change_flags_reg <= (rd_icf ? 4'h0 : change_flags_reg) | cos_new;
    end
  end

  // Fill and free-slot comparisons per channel
  generate
    for (genvar c = 0; c < 2; c++) begin : g_level
      assign rx_met[c] = (rx_evt[c].fill >= fill_level({mode_word_zero_reg[c][MW_RX_BIT],
                          mode_word_one_reg[c][MW_RX_BIT]})) || rx_evt[c].watchdog;
      assign tx_met[c] = tx_evt[c].enabled
                         && (tx_evt[c].free >= fill_level(mode_word_zero_reg[c][MW0_TX_LSB +: 2]));
    end
  endgenerate

  // Next interrupt status; break, change and timer ready sets win over their clears, queue accesses over the levels
  always_comb begin
    interrupt_status_next = interrupt_status_reg;
    for (int c = 0; c < 2; c++) begin
      // Queue access clears for one cycle, then the level re-evaluates
      interrupt_status_next[ISR_RX_A + CH_STRIDE * c] = !rx_evt[c].read && rx_met[c];
      interrupt_status_next[ISR_TX_A + CH_STRIDE * c] = !tx_evt[c].write && tx_met[c];
      if (brk_clr[c]) interrupt_status_next[ISR_BRK_A + CH_STRIDE * c] = 1'b0;
      if (rx_evt[c].brk_edge) interrupt_status_next[ISR_BRK_A + CH_STRIDE * c] = 1'b1;
    end
    if (rd_icf) interrupt_status_next[ISR_COS] = 1'b0;
    if (|(cos_new & aux_control_reg[3:0])) interrupt_status_next[ISR_COS] = 1'b1;
    if (rd_stop) interrupt_status_next[ISR_CT] = 1'b0;
    if (ct_ready_set) interrupt_status_next[ISR_CT] = 1'b1;
  end

  // Interrupt status register
  always_ff @(posedge mclk) begin
    if (reset) begin
      interrupt_status_reg <= 8'h00;
    end else begin
      interrupt_status_reg <= interrupt_status_next;
    end
  end

  // Clock source edges; the pin clock ignores the pin direction
  assign pin_edge   = pin_level[1] && !pin1_prev_reg;
  assign timer_mode = aux_control_reg[AUX_CT_MODE];
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin1_prev_reg  <= 1'b0;
      txclk_prev_reg <= 2'h0;
      pin_div_reg    <= 4'h0;
    end else begin
      pin1_prev_reg  <= pin_level[1];
      txclk_prev_reg <= tx_clk_1x;
      if (pin_edge) pin_div_reg <= pin_div_reg + 4'h1;
    end
  end

  // Mode and clock source select
  always_comb begin
    case (aux_control_reg[AUX_CT_LSB +: 3])
      3'h0, 3'h4: ct_tick = pin_edge;
      3'h1:       ct_tick = tx_clk_1x[0] && !txclk_prev_reg[0];
      3'h2:       ct_tick = tx_clk_1x[1] && !txclk_prev_reg[1];
      3'h5:       ct_tick = pin_edge && (pin_div_reg == XTAL_DIV_LAST);
      3'h6:       ct_tick = 1'b1;
      default:    ct_tick = xtal16_en_reg;
    endcase
  end

  // Ready event: timer on every second reload, counter on reaching zero
  assign ct_ready_set = ct_run_reg && ct_tick && !rd_start && !(rd_stop && !timer_mode)
                        && (timer_mode ? (count_reg <= 16'h0001) && ct_phase_reg
                                       : (count_reg == 16'h0001));

  // Counter/timer
  always_ff @(posedge mclk) begin
    if (reset) begin
      ct_run_reg   <= 1'b0;
      ct_phase_reg <= 1'b0;
      count_reg    <= 16'h0000;
      ct_out       <= 1'b1;
    end else if (rd_start) begin
      count_reg    <= preload_reg;
      ct_run_reg   <= 1'b1;
      ct_phase_reg <= 1'b0;
      ct_out       <= 1'b1;
    end else if (rd_stop && !timer_mode) begin
      ct_run_reg   <= 1'b0;
      ct_out       <= 1'b1;
    end else if (ct_run_reg && ct_tick) begin
      if (timer_mode) begin
        // Half-period ends after preload ticks; new preload taken here
        if (count_reg <= 16'h0001) begin
          count_reg    <= preload_reg;
          ct_out       <= !ct_out;
          ct_phase_reg <= !ct_phase_reg;
        end else begin
          count_reg <= count_reg - 16'h0001;
        end
      end else begin
        count_reg <= count_reg - 16'h0001;
        if (count_reg == 16'h0001) ct_out <= 1'b0;
      end
    end
  end

  // Bid: highest masked source plus one
  always_comb begin
    bid = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (interrupt_status_reg[i] && interrupt_mask_reg[i]) bid = 4'(i + 1);
    end
  end

  // Interrupt output and pin directions
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_out_n <= 1'b1;
      pin_oe    <= 8'h00;
    end else begin
      irq_out_n <= !(bid > threshold_reg);
      for (int p = 0; p < 8; p++) begin
        pin_oe[p] <= |pin_config_reg[2 * p +: 2];
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_rx_read_met;
    rx_evt[0].read ##1 (rx_met[0] && !rx_evt[0].read);
  endsequence

  sequence s_tx_write_met;
    tx_evt[0].write ##1 (tx_met[0] && !tx_evt[0].write);
  endsequence

  a_cos_enable_set: assert property ((cos_new & aux_control_reg[3:0]) != 4'h0 |=> interrupt_status_reg[ISR_COS])
    else $error("enabled change did not set status");
  a_cos_disabled_hold: assert property ((cos_new & aux_control_reg[3:0]) == 4'h0 && !rd_icf
    |=> interrupt_status_reg[ISR_COS] == $past(interrupt_status_reg[ISR_COS]))
    else $error("disabled change touched status");
  a_icf_read_clear: assert property (rd_icf && cos_new == 4'h0 |=> change_flags_reg == 4'h0
    && !interrupt_status_reg[ISR_COS])
    else $error("change register read did not clear");
  a_icf_live_pins: assert property (rd_icf |=> s_axi_rdata[3:0] == $past(pin_level))
    else $error("live pin levels wrong");
  a_irq_gate_mask: assert property ((interrupt_status_reg & interrupt_mask_reg) == 8'h00 |=> irq_out_n)
    else $error("irq without masked source");
  a_break_hold: assert property (interrupt_status_reg[ISR_BRK_A] && !brk_clr[0]
    |=> interrupt_status_reg[ISR_BRK_A])
    else $error("break status lost");
  a_rx_refill: assert property (s_rx_read_met |-> !interrupt_status_reg[ISR_RX_A] ##1
    interrupt_status_reg[ISR_RX_A])
    else $error("receiver status not restored");
  a_tx_refill: assert property (s_tx_write_met |-> !interrupt_status_reg[ISR_TX_A] ##1
    interrupt_status_reg[ISR_TX_A])
    else $error("transmit status not restored");
  a_stop_clear: assert property (rd_stop && !ct_ready_set |=> !interrupt_status_reg[ISR_CT]
    && (timer_mode ? ct_run_reg == $past(ct_run_reg) : ct_out))
    else $error("stop command misbehaved");
  a_start_load: assert property (rd_start |=> ct_run_reg && count_reg == $past(preload_reg) ##1
    ct_run_reg)
    else $error("start did not load preload");
  a_counter_zero: assert property (!timer_mode && ct_run_reg && ct_tick && count_reg == 16'h0001
    && !rd_start && !rd_stop |=> interrupt_status_reg[ISR_CT] && !ct_out && count_reg == 16'h0000)
    else $error("terminal count not flagged");

endmodule // uart_pair_irq

/* uart_pair_irq_pkg.sv */
// Constants, field layouts and carrier types for the serial pair interrupt block
package uart_pair_irq_pkg;

  // Timing: crystal clock and pin-change sampling strobe
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          STROBE_HZ     = 38_400;
  localparam int          STROBE_DIV    = CLK_HZ / STROBE_HZ;
  localparam logic [3:0]  XTAL_DIV_LAST = 4'hF;

  // Register indices; byte address is four times the index
  localparam logic [4:0]  IDX_AUX       = 5'h00;
  localparam logic [4:0]  IDX_ICF       = 5'h01;
  localparam logic [4:0]  IDX_ISR       = 5'h02;
  localparam logic [4:0]  IDX_IMR       = 5'h03;
  localparam logic [4:0]  IDX_PRE_HIGH  = 5'h04;
  localparam logic [4:0]  IDX_PRE_LOW   = 5'h05;
  localparam logic [4:0]  IDX_CNT_HIGH  = 5'h06;
  localparam logic [4:0]  IDX_CNT_LOW   = 5'h07;
  localparam logic [4:0]  IDX_MW0_A     = 5'h08;
  localparam logic [4:0]  IDX_MW1_A     = 5'h09;
  localparam logic [4:0]  IDX_MW0_B     = 5'h0A;
  localparam logic [4:0]  IDX_MW1_B     = 5'h0B;
  localparam logic [4:0]  IDX_PIN_CFG   = 5'h0C;
  localparam logic [4:0]  IDX_COMMAND   = 5'h0D;
  localparam logic [4:0]  IDX_START     = 5'h0E;
  localparam logic [4:0]  IDX_STOP      = 5'h0F;
  localparam logic [4:0]  IDX_THRESH    = 5'h10;

  // Interrupt status bit positions; channel b sits four above channel a
  localparam int          ISR_TX_A      = 0;
  localparam int          ISR_RX_A      = 1;
  localparam int          ISR_BRK_A     = 2;
  localparam int          ISR_CT        = 3;
  localparam int          ISR_COS       = 7;
  localparam int          CH_STRIDE     = 4;

  // Field positions
  localparam int          AUX_CT_LSB    = 4;
  localparam int          AUX_CT_MODE   = 6;
  localparam int          MW_RX_BIT     = 6;
  localparam int          MW0_TX_LSB    = 4;

  // Reset values
  localparam logic [7:0]  AUX_RST       = 8'h00;
  localparam logic [7:0]  IMR_RST       = 8'h00;
  localparam logic [7:0]  MW_RST        = 8'h00;
  localparam logic [15:0] PRELOAD_RST   = 16'h0002;
  localparam logic [15:0] PIN_CFG_RST   = 16'h0000;
  localparam logic [3:0]  THRESH_RST    = 4'h0;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Receiver events of one channel
  typedef struct packed {
    logic [3:0] fill;       // Bytes held in the receive queue, 0..8
    logic       watchdog;   // Enabled receive watchdog has timed out
    logic       brk_edge;   // Pulse: received break began or ended
    logic       read;       // Pulse: receive queue read
  } rx_evt_t;

  // Transmitter events of one channel
  typedef struct packed {
    logic [3:0] free;       // Empty transmit queue slots, 0..8
    logic       enabled;    // Transmitter enabled and not in reset
    logic       write;      // Pulse: transmit queue written
  } tx_evt_t;

  // Two-bit level select to a byte count
  function automatic logic [3:0] fill_level(input logic [1:0] sel);
    case (sel)
      2'h0:    return 4'h1;
      2'h1:    return 4'h4;
      2'h2:    return 4'h6;
      default: return 4'h8;
    endcase
  endfunction

endpackage

/* host_bus_model.sv */
// Host processor model driving the AXI4-Lite register bus
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input  wire logic        mclk,
  // Write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [6:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [6:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // Idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
  end

  // One write; each channel released at the edge that takes it
  task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        ok = 1;
        r = bresp;
      end
    end
    bready <= 1'b0;
  endtask

  // One read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        ok = 1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
  endtask
endmodule // host_bus_model

/* uart_pair_irq_test.sv */
// Self-checking bench for the serial pair interrupt block
`timescale 1ns/1ps
module uart_pair_irq_test;
  import uart_pair_irq_pkg::*;
  logic        mclk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ct_out, irq_out_n;
  logic [6:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, resp;
  rx_evt_t [1:0] rx_evt;
  tx_evt_t [1:0] tx_evt;
  logic [3:0]  pin_level, pins_old, pins_new;
  logic [7:0]  pin_oe;
  int          mismatches, total_checks, n_ticks;
  bit          ok, ct_seen;

  host_bus_model host_bus_model_i (.mclk(mclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  uart_pair_irq #(.STROBE_CYCLES(8)) uart_pair_irq_i (.mclk(mclk), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .rx_evt(rx_evt), .tx_evt(tx_evt), .pin_level(pin_level), .tx_clk_1x(2'h0),
    .pin_oe(pin_oe), .ct_out(ct_out), .irq_out_n(irq_out_n));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Register access by index; a hung bus ends the run
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
    host_bus_model_i.wr({idx, 2'b00}, d, resp, ok);
    if (!ok) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic reg_rd(input logic [4:0] idx);
    host_bus_model_i.rd({idx, 2'b00}, rd_data, resp, ok);
    if (!ok) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Change flags expected after a pin move
  function automatic logic [31:0] change_word(input logic [3:0] was, input logic [3:0] now);
    return {24'h0, was ^ now, now};
  endfunction

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    {rx_evt, tx_evt, pin_level, pins_old} = '0;
    {mismatches, total_checks} = '0;
    void'($urandom(35263));
    cycles(3);
    reset <= 1'b0;
    cycles(2);
    chk("pin_oe", pin_oe, 0);
    chk("ct_out", ct_out, 1);
    reg_rd(IDX_ISR);
    chk("status reset", rd_data, 0);
    tx_evt[0] <= {4'h8, 1'b1, 1'b0};
    cycles(3);
    reg_rd(IDX_ISR);
    chk("status tx", rd_data, 32'h01);
    chk("irq masked", irq_out_n, 1);
    reg_wr(IDX_IMR, 8'h01);
    cycles(3);
    chk("irq unmasked", irq_out_n, 0);
    tx_evt[0].write <= 1'b1;
    cycles(1);
    tx_evt[0].write <= 1'b0;
    cycles(1);
    #1 chk("irq after write", irq_out_n, 1);
    cycles(1);
    #1 chk("irq after refill", irq_out_n, 0);
    reg_wr(IDX_THRESH, 8'h01);
    cycles(3);
    chk("irq threshold", irq_out_n, 1);
    tx_evt[0].enabled <= 1'b0;
    cycles(3);
    reg_rd(IDX_ISR);
    chk("status tx off", rd_data, 0);
    // Receiver level four, random fill
    reg_wr(IDX_MW1_B, 8'h40);
    repeat (4) begin
      rx_evt[1].fill <= 4'($urandom_range(8));
      cycles(3);
      reg_rd(IDX_ISR);
      chk("rx status", rd_data[5], rx_evt[1].fill >= 4'h4);
    end
    rx_evt[0].brk_edge <= 1'b1;
    cycles(1);
    rx_evt[0].brk_edge <= 1'b0;
    cycles(2);
    reg_rd(IDX_ISR);
    chk("break set", rd_data[2], 1);
    reg_wr(IDX_COMMAND, 8'h01);
    reg_rd(IDX_ISR);
    chk("break clear", rd_data[2], 0);
    // Receive queue read while the level stays met
    rx_evt[0] <= {4'h2, 3'h1};
    cycles(1);
    rx_evt[0].read <= 1'b0;
    cycles(3);
    reg_rd(IDX_ISR);
    chk("rx a refilled", rd_data[1], 1);
    reg_rd(5'h1F);
    chk("unmapped", resp, RESP_SLVERR);
    reg_wr(5'h1F, 8'hFF);
    chk("unmapped write", resp, RESP_SLVERR);
    // Pin-change status enabled for all four pins, random pin moves
    reg_wr(IDX_AUX, 8'h0F);
    repeat (4) begin
      pins_new = 4'($urandom);
      pin_level <= pins_new;
      cycles(40);
      reg_rd(IDX_ISR);
      chk("change status", rd_data[7], |(pins_old ^ pins_new));
      reg_rd(IDX_ICF);
      chk("change reg", rd_data, change_word(pins_old, pins_new));
      reg_rd(IDX_ISR);
      chk("change cleared", rd_data[7], 0);
      pins_old = pins_new;
    end
    // Counter on crystal/16, change status off
    reg_wr(IDX_AUX, 8'h30);
    pin_level <= ~pins_old;
    reg_wr(IDX_PRE_HIGH, 8'h00);
    reg_wr(IDX_PRE_LOW, 8'h03);
    reg_rd(IDX_PRE_LOW);
    chk("preload unreadable", rd_data, 0);
    reg_rd(IDX_START);
    cycles(80);
    chk("ct_out terminal", ct_out, 0);
    reg_rd(IDX_ISR);
    chk("ready set", rd_data[3], 1);
    chk("change disabled", rd_data[7], 0);
    reg_rd(IDX_STOP);
    cycles(2);
    chk("ct_out stopped", ct_out, 1);
    reg_rd(IDX_ISR);
    chk("ready cleared", rd_data[3], 0);
    reg_rd(IDX_CNT_HIGH);
    chk("count wrapped", rd_data, 32'hFF);
    // Timer on crystal, half-period of 64 clocks
    reg_wr(IDX_PRE_LOW, 8'h40);
    reg_wr(IDX_AUX, 8'h60);
    reg_rd(IDX_START);
    cycles(150);
    reg_rd(IDX_ISR);
    chk("timer ready", rd_data[3], 1);
    reg_rd(IDX_STOP);
    reg_rd(IDX_ISR);
    chk("timer stop clears", rd_data[3], 0);
    ct_seen = ct_out;
    cycles(64);
    chk("timer half period", ct_out, !ct_seen);
    // Counter clocked from I/O1a while that pin is driven as an output
    reg_wr(IDX_PIN_CFG, 8'h04);
    pin_level <= 4'h0;
    reg_wr(IDX_AUX, 8'h00);
    chk("pin_oe out", pin_oe, 8'h02);
    n_ticks = $urandom_range(8, 1);
    reg_rd(IDX_START);
    repeat (n_ticks) begin
      pin_level[1] <= 1'b1;
      cycles(2);
      pin_level[1] <= 1'b0;
      cycles(2);
    end
    reg_rd(IDX_STOP);
    reg_rd(IDX_CNT_LOW);
    chk("pin clocked count", rd_data, 32'h40 - n_ticks);
    report_and_stop();
  end
endmodule // uart_pair_irq_test
